// file: hdl/bswg_pkg.sv
// Constants, field layout and state type of the burst sequencer and wait generator
// Summary of operation
// - Burst length field selects 4, 8, 16 or 32 words, or continuous.
// - Host drives the address strobe low at burst begin; start address is captured then.
// - After capture, the burst address counter advances by itself once per word.
// - Continuous mode keeps delivering sequential words until the end of the row.
// - A continuous burst ends at the end of the row or when the host drives chip select high.
// - Wrap on rolls low bits within the aligned group in fixed-length bursts; wrap off or continuous increments linearly.
// - With wrap off, a burst may keep incrementing up to the row's last column.
// - Eight-word burst, wrap off, start seven delivers addresses seven through fourteen.
// - In synchronous bursts, wait tells the host when the data is not valid.
// - Wait is asserted during initial latency and during refresh stalls.
// - Wait polarity follows the programmed polarity bit.
// - Wait asserts with the invalid data or one clock ahead, per timing select.
// - In asynchronous modes wait sits at the asserted level; host ignores it.
// - Drive strength from bits 5:4: 00 full, 01 half (default), 10 quarter.
// - Refresh is scheduled and performed internally, with no host command.
// - A row is 256 words; boundary follows every address with low byte all ones.
// - Wait asserts when an ongoing burst reaches the end of the row.
package bswg_pkg;
    localparam int ADDR_W = 22;
    localparam int CFG_W = 16;
    localparam logic [7:0] REG_CONFIG_OFS = 8'h00;
    localparam logic [7:0] REG_STATUS_OFS = 8'h04;
    localparam logic [7:0] REG_ADDR_OFS = 8'h08;
    localparam int CFG_LEN_LSB = 0;
    localparam int CFG_WRAP_BIT = 3;
    localparam int CFG_DRIVE_LSB = 4;
    localparam int CFG_WAIT_TIMING_BIT = 8;
    localparam int CFG_WAIT_POL_BIT = 10;
    localparam int CFG_LAT_LSB = 11;
    localparam int CFG_ASYNC_BIT = 15;
    localparam logic [CFG_W-1:0] CFG_RESET = 16'h9d17;
    localparam logic [CFG_W-1:0] CFG_WMASK = 16'hbd3f;
    localparam logic [2:0] LEN_4 = 3'h1;
    localparam logic [2:0] LEN_8 = 3'h2;
    localparam logic [2:0] LEN_16 = 3'h3;
    localparam logic [2:0] LEN_32 = 3'h4;
    localparam logic [2:0] LEN_CONT = 3'h7;
    localparam logic [4:0] MASK_4 = 5'h03;
    localparam logic [4:0] MASK_8 = 5'h07;
    localparam logic [4:0] MASK_16 = 5'h0f;
    localparam logic [4:0] MASK_32 = 5'h1f;
    localparam logic [7:0] ROW_LAST = 8'hff;
    localparam int STS_WAIT_BIT = 3;
    localparam int STS_REFRESH_BIT = 4;
    localparam int STS_COUNT_LSB = 8;
    localparam int CLK_PERIOD_NS = 50;
    localparam int REFRESH_INTERVAL_NS = 15600;
    localparam int REFRESH_INTERVAL_CYC = REFRESH_INTERVAL_NS / CLK_PERIOD_NS;
    localparam int REFRESH_BUSY_NS = 100;
    localparam int REFRESH_BUSY_CYC = (REFRESH_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [2:0] {ST_IDLE, ST_LATENCY, ST_BURST, ST_ROWEND, ST_DONE} bswg_state_e;
endpackage

// file: hdl/bswg_refresh.sv
// Autonomous refresh scheduler: periodic busy window that stalls burst data
`timescale 1ns/1ps
`default_nettype none
module bswg_refresh
    import bswg_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    output logic busy,
    output logic busy_next
);
    logic [15:0] interval_reg, interval_next;
    logic [15:0] busy_cnt_reg, busy_cnt_next;

    // No host trigger: interval counter alone starts each refresh
    always_comb begin
        interval_next = interval_reg + 16'h0001;
        busy_cnt_next = busy_cnt_reg;
        if (interval_reg == 16'(REFRESH_INTERVAL_CYC - 1)) begin
            interval_next = 16'h0000;
            busy_cnt_next = 16'(REFRESH_BUSY_CYC);
        end else if (busy_cnt_reg != 16'h0000) begin
            busy_cnt_next = busy_cnt_reg - 16'h0001;
        end
        busy_next = (busy_cnt_next != 16'h0000);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            interval_reg <= 16'h0000;
            busy_cnt_reg <= 16'h0000;
        end else begin
            interval_reg <= interval_next;
            busy_cnt_reg <= busy_cnt_next;
        end
    end

    assign busy = (busy_cnt_reg != 16'h0000);
endmodule
`default_nettype wire

// file: hdl/bswg_skid_buf.sv
// Two-entry buffer with registered outputs between the sequencer and the word sink
`timescale 1ns/1ps
`default_nettype none
module bswg_skid_buf #(
    parameter int W = 22
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic head_v_reg, head_v_next;
    logic spare_v_reg, spare_v_next;
    logic [W-1:0] head_d_reg, head_d_next;
    logic [W-1:0] spare_d_reg, spare_d_next;
    logic accept;

    always_comb begin
        accept = in_valid && in_ready;
        head_v_next = head_v_reg;
        head_d_next = head_d_reg;
        spare_v_next = spare_v_reg;
        spare_d_next = spare_d_reg;
        if (!head_v_reg || out_ready) begin
            if (spare_v_reg) begin
                head_v_next = 1'b1;
                head_d_next = spare_d_reg;
                spare_v_next = 1'b0;
            end else begin
                head_v_next = accept;
                if (accept) begin
                    head_d_next = in_data;
                end
            end
        end else if (accept) begin
            spare_v_next = 1'b1;
            spare_d_next = in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            head_v_reg <= 1'b0;
            spare_v_reg <= 1'b0;
            head_d_reg <= '0;
            spare_d_reg <= '0;
        end else begin
            head_v_reg <= head_v_next;
            spare_v_reg <= spare_v_next;
            head_d_reg <= head_d_next;
            spare_d_reg <= spare_d_next;
        end
    end

    assign in_ready = !spare_v_reg;
    assign out_valid = head_v_reg;
    assign out_data = head_d_reg;
endmodule
`default_nettype wire

// file: hdl/bswg_top.sv
// Burst address sequencer, wait generator and configuration registers on AHB-Lite
`timescale 1ns/1ps
`default_nettype none
module bswg_top
    import bswg_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic chip_sel_n,
    input wire logic address_latch_strobe_n,
    input wire logic [ADDR_W-1:0] addr_in,
    output logic wait_pin,
    output logic [1:0] drive_strength,
    output logic word_valid,
    input wire logic word_ready,
    output logic [ADDR_W-1:0] word_addr
);
    logic [CFG_W-1:0] cfg_reg, cfg_next;
    logic ahb_we_reg, ahb_we_next;
    logic [7:0] ahb_addr_reg, ahb_addr_next;
    logic [31:0] rdata_reg, rdata_next;
    logic hready_reg;
    logic hresp_reg;
    logic [1:0] drive_reg, drive_next;

    bswg_state_e state_reg, state_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic [4:0] count_reg, count_next;
    logic [2:0] lat_reg, lat_next;
    logic wait_reg, wait_next;

    logic sync_mode;
    logic wrap_on;
    logic wait_pol;
    logic wait_early;
    logic begin_cmd;
    logic fixed_len;
    logic [4:0] len_mask;
    logic last_word;
    logic row_end;
    logic push;
    logic buf_in_ready;
    logic ref_busy;
    logic ref_busy_next;
    logic [ADDR_W-1:0] adv_addr;
    logic [ADDR_W-1:0] group_mask;
    logic invalid_now;
    logic invalid_pred;
    logic [31:0] status_word;

    bswg_refresh bswg_refresh_i (
        .clock(clock),
        .rst(rst),
        .busy(ref_busy),
        .busy_next(ref_busy_next)
    );

    bswg_skid_buf #(.W(ADDR_W)) bswg_skid_buf_i (
        .clock(clock),
        .rst(rst),
        .in_valid(push),
        .in_ready(buf_in_ready),
        .in_data(addr_reg),
        .out_valid(word_valid),
        .out_ready(word_ready),
        .out_data(word_addr)
    );

    assign sync_mode = !cfg_reg[CFG_ASYNC_BIT];
    assign wrap_on = cfg_reg[CFG_WRAP_BIT];
    assign wait_pol = cfg_reg[CFG_WAIT_POL_BIT];
    assign wait_early = cfg_reg[CFG_WAIT_TIMING_BIT];
    assign begin_cmd = sync_mode && !chip_sel_n && !address_latch_strobe_n;

    // Burst length decode; reserved codes behave as continuous
    always_comb begin
        fixed_len = 1'b1;
        unique case (cfg_reg[CFG_LEN_LSB +: 3])
            LEN_4: len_mask = MASK_4;
            LEN_8: len_mask = MASK_8;
            LEN_16: len_mask = MASK_16;
            LEN_32: len_mask = MASK_32;
            default: begin
                len_mask = MASK_32;
                fixed_len = 1'b0;
            end
        endcase
    end

    // Wrap rolls only the bits inside the aligned group; otherwise linear count
    always_comb begin
        group_mask = {{(ADDR_W - 5){1'b0}}, len_mask};
        if (wrap_on && fixed_len) begin
            adv_addr = (addr_reg & ~group_mask) | ((addr_reg + 1'b1) & group_mask);
        end else begin
            adv_addr = addr_reg + 1'b1;
        end
    end

    assign last_word = fixed_len && (count_reg == len_mask);
    assign row_end = (addr_reg[7:0] == ROW_LAST) && !(wrap_on && fixed_len);
    assign push = (state_reg == ST_BURST) && !ref_busy && buf_in_ready;

    // Burst sequencing
    always_comb begin
        state_next = state_reg;
        addr_next = addr_reg;
        count_next = count_reg;
        lat_next = lat_reg;
        if (chip_sel_n || !sync_mode) begin
            state_next = ST_IDLE;
        end else if (begin_cmd) begin
            state_next = ST_LATENCY;
            addr_next = addr_in;
            count_next = 5'h00;
            lat_next = cfg_reg[CFG_LAT_LSB +: 3];
        end else begin
            unique case (state_reg)
                ST_LATENCY: begin
                    if (!ref_busy) begin
                        if (lat_reg <= 3'h1) begin
                            state_next = ST_BURST;
                        end else begin
                            lat_next = lat_reg - 3'h1;
                        end
                    end
                end
                ST_BURST: begin
                    if (push) begin
                        if (row_end) begin
                            state_next = ST_ROWEND;
                        end else if (last_word) begin
                            state_next = ST_DONE;
                        end else begin
                            addr_next = adv_addr;
                            count_next = count_reg + 5'h01;
                        end
                    end
                end
                ST_IDLE, ST_ROWEND, ST_DONE: begin
                end
            endcase
        end
    end

    // Wait: asserted level follows polarity; early mode looks one cycle ahead
    always_comb begin
        invalid_now = !push;
        invalid_pred = (state_next != ST_BURST) || ref_busy_next;
        if (!sync_mode) begin
            wait_next = wait_pol;
        end else if (chip_sel_n) begin
            wait_next = !wait_pol;
        end else if (wait_early ? invalid_pred : invalid_now) begin
            wait_next = wait_pol;
        end else begin
            wait_next = !wait_pol;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            addr_reg <= '0;
            count_reg <= 5'h00;
            lat_reg <= 3'h0;
            wait_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            addr_reg <= addr_next;
            count_reg <= count_next;
            lat_reg <= lat_next;
            wait_reg <= wait_next;
        end
    end

    // AHB-Lite slave: zero wait states, read data captured in the address phase
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[2:0] = state_reg;
        status_word[STS_WAIT_BIT] = wait_reg;
        status_word[STS_REFRESH_BIT] = ref_busy;
        status_word[STS_COUNT_LSB +: 5] = count_reg;
        ahb_we_next = 1'b0;
        ahb_addr_next = ahb_addr_reg;
        rdata_next = rdata_reg;
        cfg_next = cfg_reg;
        if (ahb_we_reg && ahb_addr_reg == REG_CONFIG_OFS) begin
            cfg_next = (cfg_reg & ~CFG_WMASK) | (hwdata[CFG_W-1:0] & CFG_WMASK);
        end
        if (hsel && hready && htrans[1]) begin
            ahb_we_next = hwrite;
            ahb_addr_next = haddr[7:0];
            if (!hwrite) begin
                unique case (haddr[7:0])
                    REG_CONFIG_OFS: rdata_next = {16'h0000, cfg_reg};
                    REG_STATUS_OFS: rdata_next = status_word;
                    REG_ADDR_OFS: rdata_next = {{(32 - ADDR_W){1'b0}}, addr_reg};
                    default: rdata_next = 32'h0000_0000;
                endcase
            end
        end
        drive_next = cfg_next[CFG_DRIVE_LSB +: 2];
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cfg_reg <= CFG_RESET;
            ahb_we_reg <= 1'b0;
            ahb_addr_reg <= 8'h00;
            rdata_reg <= 32'h0000_0000;
            hready_reg <= 1'b1;
            hresp_reg <= 1'b0;
            drive_reg <= CFG_RESET[CFG_DRIVE_LSB +: 2];
        end else begin
            cfg_reg <= cfg_next;
            ahb_we_reg <= ahb_we_next;
            ahb_addr_reg <= ahb_addr_next;
            rdata_reg <= rdata_next;
            hready_reg <= 1'b1;
            hresp_reg <= 1'b0;
            drive_reg <= drive_next;
        end
    end

    assign hrdata = rdata_reg;
    assign hreadyout = hready_reg;
    assign hresp = hresp_reg;
    assign wait_pin = wait_reg;
    assign drive_strength = drive_reg;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    property p_capture;
        begin_cmd |=> (addr_reg == $past(addr_in)) && (state_reg == ST_LATENCY);
    endproperty
    a_capture: assert property (p_capture) else $error("start address not captured");

    property p_wrap_group;
        push && wrap_on && fixed_len && !last_word && !chip_sel_n && address_latch_strobe_n
            |=> (addr_reg & ~$past(group_mask)) == $past(addr_reg & ~group_mask);
    endproperty
    a_wrap_group: assert property (p_wrap_group) else $error("wrap left the group");

    property p_linear;
        push && !(wrap_on && fixed_len) && !last_word && !row_end && !chip_sel_n
            && address_latch_strobe_n |=> addr_reg == $past(addr_reg) + 1'b1;
    endproperty
    a_linear: assert property (p_linear) else $error("linear advance wrong");

    property p_cs_end;
        chip_sel_n |=> (state_reg == ST_IDLE) && !push;
    endproperty
    a_cs_end: assert property (p_cs_end) else $error("burst ran past chip select");

    property p_fixed_stop;
        push && last_word |=> !push;
    endproperty
    a_fixed_stop: assert property (p_fixed_stop) else $error("word after fixed burst");

    property p_count_bound;
        push && fixed_len |-> count_reg <= len_mask;
    endproperty
    a_count_bound: assert property (p_count_bound) else $error("burst count overrun");

    property p_refresh_stall;
        ref_busy |-> !push;
    endproperty
    a_refresh_stall: assert property (p_refresh_stall) else $error("word during refresh");

    property p_refresh_wait;
        ref_busy && sync_mode && !chip_sel_n && !wait_early |=> wait_pin == $past(wait_pol);
    endproperty
    a_refresh_wait: assert property (p_refresh_wait) else $error("no wait during refresh");

    property p_async_wait;
        !sync_mode |=> wait_pin == $past(wait_pol);
    endproperty
    a_async_wait: assert property (p_async_wait) else $error("async wait not asserted");

    property p_row_end_wait;
        (state_reg == ST_ROWEND) && !chip_sel_n && address_latch_strobe_n && sync_mode
            && !wait_early |=> wait_pin == $past(wait_pol);
    endproperty
    a_row_end_wait: assert property (p_row_end_wait) else $error("no wait at row end");

    property p_idle_wait;
        sync_mode && chip_sel_n |=> wait_pin == !$past(wait_pol);
    endproperty
    a_idle_wait: assert property (p_idle_wait) else $error("wait polarity wrong");
endmodule
`default_nettype wire

// file: test/bswg_host_model.sv
// Host memory controller model: burst begin, termination and word sink
`timescale 1ns/1ps
`default_nettype none
module bswg_host_model
    import bswg_pkg::*;
(
    input wire logic clock,
    input wire logic stall,
    output logic chip_sel_n,
    output logic address_latch_strobe_n,
    output logic [ADDR_W-1:0] addr_in,
    output logic word_ready
);
    initial begin
        chip_sel_n = 1'b1;
        address_latch_strobe_n = 1'b1;
        addr_in = '0;
        word_ready = 1'b0;
    end
    // Sink stalls at random so the buffer has to hold words
    always @(posedge clock) begin
        word_ready <= !stall;
    end
    // Chip select toggles high first, then the begin comes with the strobe low
    task automatic begin_burst(input logic [ADDR_W-1:0] a);
        @(posedge clock);
        chip_sel_n <= 1'b1;
        @(posedge clock);
        chip_sel_n <= 1'b0;
        address_latch_strobe_n <= 1'b0;
        addr_in <= a;
        @(posedge clock);
        address_latch_strobe_n <= 1'b1;
        addr_in <= ~a;
    endtask
    // A high chip select ends a burst at any point; wait is not used in async mode
    task automatic end_burst();
        @(posedge clock);
        chip_sel_n <= 1'b1;
    endtask
endmodule
`default_nettype wire

// file: test/bswg_test.sv
// Self-checking bench for the burst sequencer and wait generator
`timescale 1ns/1ps
`default_nettype none
module bswg_test
    import bswg_pkg::*;
;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic chip_sel_n;
    logic address_latch_strobe_n;
    logic [ADDR_W-1:0] addr_in;
    logic wait_pin;
    logic [1:0] drive_strength;
    logic word_valid;
    logic word_ready;
    logic [ADDR_W-1:0] word_addr;
    logic stall = 1'b0;
    logic stall_en = 1'b0;
    logic [31:0] lfsr = 32'h0001_5ace;
    logic [ADDR_W-1:0] exp_q[$];
    logic [ADDR_W-1:0] e;
    logic [ADDR_W-1:0] start;
    logic [31:0] d;
    int n_mismatch = 0;
    int samples_checked = 0;
    int dw[2];
    int n;

    always #25 clock = ~clock;

    bswg_top bswg_top_i (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .chip_sel_n(chip_sel_n), .address_latch_strobe_n(address_latch_strobe_n),
        .addr_in(addr_in), .wait_pin(wait_pin), .drive_strength(drive_strength),
        .word_valid(word_valid), .word_ready(word_ready), .word_addr(word_addr));

    bswg_host_model bswg_host_model_i (.clock(clock), .stall(stall), .chip_sel_n(chip_sel_n),
        .address_latch_strobe_n(address_latch_strobe_n), .addr_in(addr_in),
        .word_ready(word_ready));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    always @(posedge clock) begin
        lfsr <= lfsr_next(lfsr);
        stall <= stall_en & lfsr[0];
    end

    function automatic logic [31:0] cfg(input logic [2:0] len, input logic wrap,
        input logic [1:0] drv, input logic wc, input logic pol, input logic asy);
        logic [31:0] c;
        c = '0;
        c[CFG_LEN_LSB +: 3] = len;
        c[CFG_WRAP_BIT] = wrap;
        c[CFG_DRIVE_LSB +: 2] = drv;
        c[CFG_WAIT_TIMING_BIT] = wc;
        c[CFG_WAIT_POL_BIT] = pol;
        c[CFG_LAT_LSB +: 3] = 3'h2;
        c[CFG_ASYNC_BIT] = asy;
        return c;
    endfunction

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    task automatic hang(input string msg);
        n_mismatch++;
        $display("mismatch at %0t: timeout in %s", $time, msg);
        end_sim();
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        int k;
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        k = 0;
        do begin @(posedge clock); k++; end while (hreadyout !== 1'b1 && k < 50);
        if (k >= 50) hang("bus address");
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin @(posedge clock); k++; end while (hreadyout !== 1'b1 && k < 100);
        rd = hrdata;
        if (k >= 100) hang("bus");
        check(hresp === 1'b0, "bus response not okay");
    endtask

    task automatic drain();
        int k;
        k = 0;
        while (exp_q.size() > 0 && k < 3000) begin @(posedge clock); k++; end
        if (k >= 3000) hang("burst");
        repeat (40) @(posedge clock);
    endtask

    // Uneven read spacing so the short busy window cannot keep slipping between samples
    task automatic see_refresh(output int hit);
        logic [31:0] r;
        hit = 0;
        for (int k = 0; k < 500 && hit == 0; k++) begin
            ahb(1'b0, 32'(REG_STATUS_OFS), '0, r);
            if (r[STS_REFRESH_BIT] === 1'b1) hit = 1;
            repeat (k % 2) @(posedge clock);
        end
    endtask

    task automatic run_burst(input logic [2:0] len, input logic wrap, input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] mk;
        int full;
        int nw;
        mk = ADDR_W'(len == LEN_4 ? MASK_4 : len == LEN_8 ? MASK_8 : len == LEN_16 ? MASK_16 : MASK_32);
        full = int'(mk) + 1;
        nw = full;
        if (len == LEN_CONT || (!wrap && full > 256 - int'(a[7:0]))) nw = 256 - int'(a[7:0]);
        ahb(1'b1, 32'(REG_CONFIG_OFS), cfg(len, wrap, 2'h1, 1'b0, 1'b1, 1'b0), d);
        for (int i = 0; i < nw; i++)
            exp_q.push_back(wrap ? ((a & ~mk) | ((a + ADDR_W'(i)) & mk)) : a + ADDR_W'(i));
        bswg_host_model_i.begin_burst(a);
        drain();
        if (nw != full) check(wait_pin === 1'b1, "no wait at row end");
        bswg_host_model_i.end_burst();
        $display("test burst len %0d wrap %0d start %h done", len, wrap, a);
    endtask

    always @(posedge clock) begin
        if (!rst && word_valid === 1'b1 && word_ready === 1'b1) begin
            samples_checked++;
            if (exp_q.size() == 0) begin
                n_mismatch++;
                $display("mismatch at %0t: unexpected word %h", $time, word_addr);
            end else begin
                e = exp_q.pop_front();
                if (word_addr !== e) begin
                    n_mismatch++;
                    $display("mismatch at %0t: word %h expected %h", $time, word_addr, e);
                end
            end
        end
    end

    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        ahb(1'b0, 32'(REG_CONFIG_OFS), '0, d);
        check(d === 32'(CFG_RESET), "config reset value");
        check(drive_strength === 2'h1, "drive strength reset");
        ahb(1'b0, 32'h0000_000c, '0, d);
        check(d === 32'h0000_0000, "unmapped read");
        $display("test reset done");
        for (int s = 0; s < 3; s++) begin
            ahb(1'b1, 32'(REG_CONFIG_OFS), cfg(LEN_4, 1'b0, 2'(s), 1'b0, 1'b1, 1'b0), d);
            ahb(1'b0, 32'(REG_CONFIG_OFS), '0, d);
            check(d === (cfg(LEN_4, 1'b0, 2'(s), 1'b0, 1'b1, 1'b0) & 32'(CFG_WMASK)), "readback");
            check(drive_strength === 2'(s), "drive strength");
        end
        $display("test drive done");
        for (int p = 0; p < 2; p++) begin
            ahb(1'b1, 32'(REG_CONFIG_OFS), cfg(LEN_4, 1'b0, 2'h1, 1'b0, 1'(p), 1'b1), d);
            bswg_host_model_i.begin_burst(22'h00_0010);
            repeat (10) @(posedge clock);
            #1;
            check(wait_pin === 1'(p), "async wait level");
            bswg_host_model_i.end_burst();
        end
        $display("test async done");
        for (int p = 0; p < 2; p++) begin
            for (int wc = 0; wc < 2; wc++) begin
                ahb(1'b1, 32'(REG_CONFIG_OFS), cfg(LEN_4, 1'b0, 2'h1, 1'(wc), 1'(p), 1'b0), d);
                // Start just after a refresh so both timing runs see the same stall-free latency
                see_refresh(n);
                for (int i = 0; i < 4; i++) exp_q.push_back(22'h00_0040 + ADDR_W'(i));
                bswg_host_model_i.begin_burst(22'h00_0040);
                #1;
                check(wait_pin === 1'(p), "wait in latency");
                n = 0;
                while (wait_pin !== 1'(!p) && n < 50) begin @(posedge clock); #1; n++; end
                check(n < 50, "wait never released");
                dw[wc] = n;
                drain();
                bswg_host_model_i.end_burst();
            end
            check(dw[0] - dw[1] == 1, "early wait not one cycle ahead");
        end
        $display("test wait done");
        stall_en <= 1'b1;
        for (int l = 0; l < 4; l++) begin
            for (int w = 0; w < 2; w++) begin
                start = (l == 1 && w == 0) ? 22'h00_0007 : {12'h001, 2'(l), lfsr[7:0]};
                run_burst(LEN_4 + 3'(l), 1'(w), start);
            end
        end
        run_burst(LEN_CONT, 1'b0, 22'h00_02f8);
        see_refresh(n);
        check(n == 1, "no refresh seen");
        $display("test refresh done");
        end_sim();
    end
endmodule
`default_nettype wire
